// ===== inc/drlp_regs.vh
// drlp_regs.vh: constants for the demand reset lockout and pulser block
// assumes: included by bare name from core files
`ifndef DRLP_REGS_VH
`define DRLP_REGS_VH
// ==========================================
// timing
`define DRLP_CLK_HZ        25000000
`define DRLP_LOCKOUT_S     2160000
`define DRLP_DEBOUNCE_MS   20
`define DRLP_DEBOUNCE_CYC  ((`DRLP_CLK_HZ / 1000) * `DRLP_DEBOUNCE_MS)
`define DRLP_PULSE_MS      10
`define DRLP_PULSE_CYC     ((`DRLP_CLK_HZ / 1000) * `DRLP_PULSE_MS)
// ==========================================
// pulser defaults
`define DRLP_RATE_DEFAULT  32'h00000001
`define DRLP_PULSE_ON      1'b1
`endif

// ===== core/drlp_pulser.v
// drlp_pulser.v: one energy pulse channel, led and infrared copy
// assumes: energy quanta arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
`default_nettype none
module drlp_pulser #(
   parameter RW = 32,
   parameter PW = 24
) (
   // clock and reset
   input  wire          clk,
   input  wire          nrst,
   // setup
   input  wire          enable,
   input  wire [RW-1:0] rate,
   input  wire [PW-1:0] width,
   // energy
   input  wire          quantum,
   // outputs
   output reg           led,
   output reg           ir
);
   reg [RW-1:0] acc;
   reg [PW-1:0] hold;
   wire         fire = enable && quantum && (acc + 1'b1 >= rate);
   // one source for led and infrared, so the two can never drift apart
   wire         next_led = fire || (hold > {{(PW-1){1'b0}}, 1'b1});
   // ==========================================
   // quanta divided by rate; rate change takes effect at once
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc  <= {RW{1'b0}};
         hold <= {PW{1'b0}};
         led  <= 1'b0;
         ir   <= 1'b0;
      end else begin
         if (!enable) begin
            acc <= {RW{1'b0}};
         end else if (fire) begin
            acc <= {RW{1'b0}};
         end else if (quantum) begin
            acc <= acc + 1'b1;
         end
         if (fire) begin
            hold <= width;
         end else if (hold != {PW{1'b0}}) begin
            hold <= hold - 1'b1;
         end
         led <= next_led;
         ir  <= next_led;
      end
   end
endmodule // drlp_pulser
`default_nettype wire

// ===== core/drlp_top.v
// drlp_top.v: demand reset lockout with test mode steering, two energy pulsers
// assumes: switch and test inputs synchronous to CLK; SEC_TICK one pulse per second
`timescale 1ns/1ps
`default_nettype none
`include "drlp_regs.vh"
module drlp_top #(
   parameter LOCKOUT_S   = `DRLP_LOCKOUT_S,
   parameter DEBOUNCE_CY = `DRLP_DEBOUNCE_CYC,
   parameter PULSE_CY    = `DRLP_PULSE_CYC,
   parameter RW          = 32
) (
   // clock and reset
   input  wire          CLK,
   input  wire          NRST,
   // time base and mode
   input  wire          SEC_TICK,
   input  wire          TEST_MODE,
   // demand reset switch, high while pressed
   input  wire          RESET_SW,
   // lockout setup
   input  wire [31:0]   LOCKOUT_VAL,
   input  wire          LOCKOUT_LOAD,
   // energy quanta and pulser setup
   input  wire          KWH_QUANTUM,
   input  wire          KVARH_QUANTUM,
   input  wire [RW-1:0] KWH_RATE,
   input  wire [RW-1:0] KVARH_RATE,
   input  wire          PULSE_EN_LOAD,
   input  wire [1:0]    PULSE_EN_VAL,
   // demand reset outcomes
   output reg           CLEAR_PEAK,
   output reg           CLEAR_TEST_DEMAND,
   output reg           RESET_IGNORED,
   output reg           LOCKOUT_ACTIVE,
   // accumulation steering
   output reg           BILL_ACC_EN,
   output reg           TEST_ACC_EN,
   // pulse outputs
   output wire          LED_KWH,
   output wire          LED_KVARH,
   output wire          IR_KWH,
   output wire          IR_KVARH
);
   localparam [23:0] PW_CY = PULSE_CY[23:0];
   localparam [23:0] DB_CY = DEBOUNCE_CY[23:0];
   localparam [31:0] LK_S  = LOCKOUT_S;
   reg  [23:0] db_cnt;
   reg         sw_stable;
   reg         sw_prev;
   reg  [31:0] lockout;
   reg  [31:0] elapsed;
   reg         have_reset;
   reg  [1:0]  pulse_en;
   wire        press;
   wire        locked;
   // ==========================================
   // debounce: level must hold DB_CY cycles before it counts
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         db_cnt    <= 24'h000000;
         sw_stable <= 1'b0;
         sw_prev   <= 1'b0;
      end else begin
         sw_prev <= sw_stable;
         if (RESET_SW == sw_stable) begin
            db_cnt <= 24'h000000;
         end else if (db_cnt >= DB_CY - 24'h000001) begin
            sw_stable <= RESET_SW;
            db_cnt    <= 24'h000000;
         end else begin
            db_cnt <= db_cnt + 24'h000001;
         end
      end
   end
   assign press = sw_stable && !sw_prev;
   // ==========================================
   // lockout; first press after power-up is always accepted
   assign locked = have_reset && (elapsed < lockout);
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         lockout           <= LK_S;
         elapsed           <= 32'h00000000;
         have_reset        <= 1'b0;
         CLEAR_PEAK        <= 1'b0;
         CLEAR_TEST_DEMAND <= 1'b0;
         RESET_IGNORED     <= 1'b0;
         LOCKOUT_ACTIVE    <= 1'b0;
      end else begin
         CLEAR_PEAK        <= 1'b0;
         CLEAR_TEST_DEMAND <= 1'b0;
         RESET_IGNORED     <= 1'b0;
         if (LOCKOUT_LOAD) begin
            lockout <= LOCKOUT_VAL;
         end
         if (press && !locked) begin
            elapsed    <= 32'h00000000;
            have_reset <= 1'b1;
            CLEAR_PEAK        <= !TEST_MODE;
            CLEAR_TEST_DEMAND <= TEST_MODE;
         end else begin
            if (press) begin
               RESET_IGNORED <= 1'b1;
            end
            // saturate so a very long idle never wraps into lockout
            if (SEC_TICK && elapsed != 32'hFFFFFFFF) begin
               elapsed <= elapsed + 32'h00000001;
            end
         end
         LOCKOUT_ACTIVE <= locked;
      end
   end
   // ==========================================
   // accumulation steering
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         BILL_ACC_EN <= 1'b1;
         TEST_ACC_EN <= 1'b0;
      end else begin
         BILL_ACC_EN <= !TEST_MODE;
         TEST_ACC_EN <= TEST_MODE;
      end
   end
   // ==========================================
   // pulsers, enabled by default
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pulse_en <= {`DRLP_PULSE_ON, `DRLP_PULSE_ON};
      end else if (PULSE_EN_LOAD) begin
         pulse_en <= PULSE_EN_VAL;
      end
   end
   drlp_pulser #(.RW(RW), .PW(24)) u_kwh (
      .clk     (CLK),
      .nrst    (NRST),
      .enable  (pulse_en[0]),
      .rate    (KWH_RATE),
      .width   (PW_CY),
      .quantum (KWH_QUANTUM),
      .led     (LED_KWH),
      .ir      (IR_KWH)
   );
   drlp_pulser #(.RW(RW), .PW(24)) u_kvarh (
      .clk     (CLK),
      .nrst    (NRST),
      .enable  (pulse_en[1]),
      .rate    (KVARH_RATE),
      .width   (PW_CY),
      .quantum (KVARH_QUANTUM),
      .led     (LED_KVARH),
      .ir      (IR_KVARH)
   );
endmodule // drlp_top
`default_nettype wire

// ===== dv/drlp_assertions.sv
// drlp_assertions.sv: port checker for drlp_top
// assumes: TEST_MODE steady around a press
`timescale 1ns/1ps
`default_nettype none
module drlp_chk (
   // clock, reset, inputs
   input wire logic CLK, NRST, TEST_MODE, RESET_SW,
   // outcomes and steering
   input wire logic CLEAR_PEAK, CLEAR_TEST_DEMAND, RESET_IGNORED, LOCKOUT_ACTIVE,
   input wire logic BILL_ACC_EN, TEST_ACC_EN,
   // pulse outputs
   input wire logic LED_KWH, LED_KVARH, IR_KWH, IR_KVARH
);
   // ==========
   // checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   peak_mode_a: assert property (CLEAR_PEAK |-> !$past(TEST_MODE) && $past(RESET_SW, 2))
      else $error("peak clear in test mode");
   test_clr_a: assert property (CLEAR_TEST_DEMAND |-> $past(TEST_MODE) && !CLEAR_PEAK)
      else $error("test clear outside test mode");
   ign_lock_a: assert property (RESET_IGNORED |-> LOCKOUT_ACTIVE && !CLEAR_PEAK)
      else $error("ignored without lockout");
   lock_start_a: assert property (CLEAR_PEAK || CLEAR_TEST_DEMAND |-> ##[1:2] LOCKOUT_ACTIVE)
      else $error("lockout not restarted");
   peak_once_a: assert property (CLEAR_PEAK |=> !CLEAR_PEAK)
      else $error("peak clear too long");
   bill_mode_a: assert property (BILL_ACC_EN == !$past(TEST_MODE))
      else $error("billing enable wrong");
   test_acc_a: assert property (TEST_ACC_EN == $past(TEST_MODE))
      else $error("test accumulate wrong");
   ir_kwh_a: assert property (IR_KWH == LED_KWH)
      else $error("kwh ir differs");
   ir_kvar_a: assert property (IR_KVARH == LED_KVARH)
      else $error("kvarh ir differs");
endmodule // drlp_chk
bind drlp_top drlp_chk drlp_chk_inst (
   .CLK               (CLK),
   .NRST              (NRST),
   .TEST_MODE         (TEST_MODE),
   .RESET_SW          (RESET_SW),
   .CLEAR_PEAK        (CLEAR_PEAK),
   .CLEAR_TEST_DEMAND (CLEAR_TEST_DEMAND),
   .RESET_IGNORED     (RESET_IGNORED),
   .LOCKOUT_ACTIVE    (LOCKOUT_ACTIVE),
   .BILL_ACC_EN       (BILL_ACC_EN),
   .TEST_ACC_EN       (TEST_ACC_EN),
   .LED_KWH           (LED_KWH),
   .LED_KVARH         (LED_KVARH),
   .IR_KWH            (IR_KWH),
   .IR_KVARH          (IR_KVARH)
);
`default_nettype wire

// ===== dv/drlp_panel.sv
// drlp_panel.sv: bouncing switch and infrared pulse counter
// assumes: driven from the bench clock
`timescale 1ns/1ps
`default_nettype none
module drlp_panel (
   input wire logic clk, press, ir_kwh, ir_kvarh,
   output logic     sw,
   output int       n_kwh, n_kvarh
);
   logic [1:0] ch;
   logic [1:0] ir_q;
   initial begin
      ch = 2'h0;
      sw = 1'b0;
      ir_q = 2'h0;
      n_kwh = 0;
      n_kvarh = 0;
   end
   // ==========
   // contact chatter on close, so debounce is exercised
   always @(posedge clk) begin
      ch <= press ? (ch == 2'h3 ? ch : ch + 2'h1) : 2'h0;
      sw <= press && ch != 2'h1;
      ir_q <= {ir_kvarh, ir_kwh};
      if (ir_kwh && !ir_q[0]) n_kwh <= n_kwh + 1;
      if (ir_kvarh && !ir_q[1]) n_kvarh <= n_kvarh + 1;
   end
endmodule // drlp_panel
`default_nettype wire

// ===== dv/drlp_top_test.sv
// drlp_top_test.sv: bench for drlp_top
// assumes: short debounce and pulse counts
`timescale 1ns/1ps
`default_nettype none
module drlp_top_test;
   logic clk = 0, nrst = 0, sec = 0, tmode = 0, press = 0, lload = 0, qk = 0, qv = 0, eld = 0;
   logic [31:0] lval = 32'h0, rk = 32'h1, rv = 32'h1;
   logic [1:0] ev = 2'h3;
   wire logic sw, cp, ct, ig, la, be, te, lk, lv, ik, iv;
   int fail_count = 0, check_count = 0, cyc = 0, nk, nv;
   // led pulses counted here, infrared ones in the panel model
   logic [1:0] led_q = 2'h0;
   int nlk = 0, nlv = 0;
   always @(posedge clk) begin
      led_q <= {lv, lk};
      if (lk === 1'b1 && led_q[0] === 1'b0) nlk <= nlk + 1;
      if (lv === 1'b1 && led_q[1] === 1'b0) nlv <= nlv + 1;
   end
   drlp_top #(.DEBOUNCE_CY(4), .PULSE_CY(4)) drlp_top_inst (.CLK(clk), .NRST(nrst),
      .SEC_TICK(sec), .TEST_MODE(tmode), .RESET_SW(sw), .LOCKOUT_VAL(lval),
      .LOCKOUT_LOAD(lload), .KWH_QUANTUM(qk), .KVARH_QUANTUM(qv), .KWH_RATE(rk),
      .KVARH_RATE(rv), .PULSE_EN_LOAD(eld), .PULSE_EN_VAL(ev), .CLEAR_PEAK(cp),
      .CLEAR_TEST_DEMAND(ct), .RESET_IGNORED(ig), .LOCKOUT_ACTIVE(la), .BILL_ACC_EN(be),
      .TEST_ACC_EN(te), .LED_KWH(lk), .LED_KVARH(lv), .IR_KWH(ik), .IR_KVARH(iv));
   drlp_panel drlp_panel_inst (.clk(clk), .press(press), .ir_kwh(ik), .ir_kvarh(iv),
      .sw(sw), .n_kwh(nk), .n_kvarh(nv));
   always #20 clk = ~clk;
   // ==========
   // helpers
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   task automatic secs(int n);
      repeat (n) begin
         @(posedge clk) sec <= 1;
         @(posedge clk) sec <= 0;
      end
   endtask
   // one press: outcome bits {peak, test, ignored}, one pulse only
   task automatic push(string nm, logic [2:0] exp);
      logic [2:0] seen;
      int n;
      seen = 3'h0;
      n = 0;
      for (int i = 0; i < 26; i++) begin
         @(posedge clk) press <= (i < 12);
         #1 seen = seen | {cp, ct, ig};
         n = n + cp + ct + ig;
      end
      chk(nm, {29'h0, exp}, {29'h0, seen});
      chk("one_per_press", 1, n);
   endtask
   task automatic quanta(int n);
      repeat (n) begin
         @(posedge clk) {qk, qv} <= 2'h3;
         @(posedge clk) {qk, qv} <= 2'h0;
         repeat (10) @(posedge clk);
      end
   endtask
   // ==========
   // scenarios
   task automatic t_lockout;
      push("first", 3'h4);
      push("dflt", 3'h1);
      chk("lock_on", 1, la);
      @(posedge clk) {lval, lload} <= {32'h3, 1'b1};
      @(posedge clk) lload <= 0;
      secs(3);
      repeat (2) @(posedge clk);
      chk("lock_off", 0, la);
      push("after", 3'h4);
      secs(2);
      push("early", 3'h1);
      secs(1);
      push("no_restart", 3'h4);
   endtask
   task automatic t_test;
      secs(3);
      @(posedge clk) tmode <= 1;
      repeat (2) @(posedge clk);
      chk("bill_en", 0, be);
      push("test_clr", 3'h2);
      @(posedge clk) tmode <= 0;
   endtask
   task automatic t_pulse;
      @(posedge clk) {rk, rv} <= {32'h2, 32'h1};
      quanta(4);
      chk("ir_kwh", 2, nk);
      chk("ir_kvarh", 4, nv);
      @(posedge clk) {eld, ev} <= 3'h5;
      @(posedge clk) eld <= 0;
      quanta(2);
      chk("kwh_on", 3, nk);
      chk("kvarh_off", 4, nv);
      chk("led_kwh", 3, nlk);
      chk("led_kvarh", 4, nlv);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1;
      repeat (2) @(posedge clk);
      chk("leds", 0, {lk, lv});
      chk("acc", 2, {be, te});
      t_lockout();
      t_test();
      t_pulse();
      wrap_up();
   end
endmodule // drlp_top_test
`default_nettype wire
